//--- hw/cpl_palette_port.sv
// Function
// - select lines pick pointer, staging or mask
// - palette holds 256 entries of 18 bits
// - host access independent of pixel stream
// - three byte accesses per color, counted
// - write keeps six low data bits
// - read drives component, top bits zero
// - blue write stores entry, pointer increments
// - read-mode index loads staging, pointer increments
// - reads return red, green, then blue
// - finished read reloads staging, increments again
// - pointer write restarts sequence at red
// - update may briefly show pointer entry
// - eight bit mask readable and writable
// - mask bit one keeps index bit
// - host accesses use unmasked pointer
// - three cycle pixel pipeline
// - output latch feeds three channels
// - video off forces zero outputs
// - write data taken at strobe rising edge
// - data lines driven during read, delayed one clock
`include "cpl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpl_palette_port #(
    parameter int ENTRIES = 256,
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // host port
    input wire logic i_reg_select_lo,
    input wire logic i_reg_select_hi,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire cpl_pkg::cpl_byte_t i_host_data,
    output var cpl_pkg::cpl_byte_t o_host_data,
    output logic o_host_data_oe,
    // pixel input
    input wire cpl_pkg::cpl_byte_t i_pixel_index_in,
    input wire logic i_video_off_n,
    output logic o_pixel_ready,
    // dac channels
    output var cpl_pkg::cpl_comp6_t o_dac_red,
    output var cpl_pkg::cpl_comp6_t o_dac_green,
    output var cpl_pkg::cpl_comp6_t o_dac_blue,
    output logic o_dac_valid,
    input wire logic i_dac_ready
);
    import cpl_pkg::*;

    logic [17:0] pal_mem [ENTRIES];
    logic rd_q_reg;
    logic wr_q_reg;
    cpl_sel_t sel_reg;
    cpl_byte_t wr_data_reg;
    cpl_byte_t ptr_reg;
    cpl_byte_t mask_reg;
    logic [17:0] staging_reg;
    cpl_phase_t phase_reg;
    logic read_mode_reg;
    cpl_byte_t s1_idx_reg;
    logic s1_on_reg;
    logic s1_valid_reg;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    cpl_sel_t acc_sel;
    cpl_byte_t rd_mux;
    logic pal_we;
    logic [17:0] pal_wdata;
    cpl_byte_t fetch_idx;
    logic [17:0] fetch_data;
    cpl_byte_t look_idx;
    logic [17:0] look_data;
    logic out_ready;

    cpl_stream_if #(.W(18)) pix_in ();
    cpl_stream_if #(.W(18)) pix_out ();

    // strobes are plain synchronous pins; one stage gives the edge history
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rd_q_reg <= 1'b1;
            wr_q_reg <= 1'b1;
        end else begin
            rd_q_reg <= i_read_strobe_n;
            wr_q_reg <= i_write_strobe_n;
        end
    end

    assign rd_fall = rd_q_reg && !i_read_strobe_n;
    assign rd_rise = !rd_q_reg && i_read_strobe_n;
    assign wr_fall = wr_q_reg && !i_write_strobe_n;
    assign wr_rise = !wr_q_reg && i_write_strobe_n;
    assign acc_sel = (rd_fall || wr_fall) ? {i_reg_select_hi, i_reg_select_lo} : sel_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sel_reg <= `CPL_SEL_PTR_WR;
        end else if (rd_fall || wr_fall) begin
            sel_reg <= {i_reg_select_hi, i_reg_select_lo};
        end
    end

    // last sample while the strobe is low is what the rising edge latches
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_data_reg <= 8'h00;
        end else if (!i_write_strobe_n) begin
            wr_data_reg <= i_host_data;
        end
    end

    assign pal_we = wr_rise && (sel_reg == `CPL_SEL_COLOR) && (phase_reg == CPL_BLUE);
    assign pal_wdata = {staging_reg[`CPL_RED_MSB:`CPL_GREEN_LSB], wr_data_reg[5:0]};
    // host side addresses by the raw pointer, or by the written index on a read-index write
    assign fetch_idx = (wr_rise && sel_reg == `CPL_SEL_PTR_RD) ? wr_data_reg : ptr_reg;
    assign fetch_data = pal_mem[fetch_idx];

    always_ff @(posedge i_clk) begin
        if (pal_we) begin
            pal_mem[ptr_reg] <= pal_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            phase_reg <= CPL_RED;
            ptr_reg <= `CPL_PTR_RST;
            read_mode_reg <= 1'b0;
            staging_reg <= `CPL_STAGE_RST;
        end else if (wr_rise) begin
            unique case (sel_reg)
                `CPL_SEL_PTR_WR: begin
                    ptr_reg <= wr_data_reg;
                    phase_reg <= CPL_RED;
                    read_mode_reg <= 1'b0;
                end
                `CPL_SEL_PTR_RD: begin
                    staging_reg <= fetch_data;
                    ptr_reg <= 8'(wr_data_reg + 1'b1);
                    phase_reg <= CPL_RED;
                    read_mode_reg <= 1'b1;
                end
                `CPL_SEL_COLOR: begin
                    unique case (phase_reg)
                        CPL_RED: begin
                            staging_reg[`CPL_RED_MSB:`CPL_RED_LSB] <= wr_data_reg[5:0];
                            phase_reg <= CPL_GREEN;
                        end
                        CPL_GREEN: begin
                            staging_reg[`CPL_GREEN_MSB:`CPL_GREEN_LSB] <= wr_data_reg[5:0];
                            phase_reg <= CPL_BLUE;
                        end
                        CPL_BLUE: begin
                            staging_reg[`CPL_BLUE_MSB:`CPL_BLUE_LSB] <= wr_data_reg[5:0];
                            ptr_reg <= 8'(ptr_reg + 1'b1);
                            phase_reg <= CPL_RED;
                        end
                        default: begin
                            phase_reg <= CPL_RED;
                        end
                    endcase
                end
                `CPL_SEL_MASK: begin
                    read_mode_reg <= read_mode_reg;
                end
            endcase
        end else if (rd_rise && sel_reg == `CPL_SEL_COLOR) begin
            unique case (phase_reg)
                CPL_RED: phase_reg <= CPL_GREEN;
                CPL_GREEN: phase_reg <= CPL_BLUE;
                CPL_BLUE: begin
                    phase_reg <= CPL_RED;
                    if (read_mode_reg) begin
                        staging_reg <= fetch_data;
                        ptr_reg <= 8'(ptr_reg + 1'b1);
                    end
                end
                default: phase_reg <= CPL_RED;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mask_reg <= `CPL_MASK_RST;
        end else if (wr_rise && sel_reg == `CPL_SEL_MASK) begin
            mask_reg <= wr_data_reg;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        unique case (acc_sel)
            `CPL_SEL_PTR_WR, `CPL_SEL_PTR_RD: rd_mux = ptr_reg;
            `CPL_SEL_MASK: rd_mux = mask_reg;
            `CPL_SEL_COLOR: begin
                unique case (phase_reg)
                    CPL_GREEN: rd_mux = {2'h0, staging_reg[`CPL_GREEN_MSB:`CPL_GREEN_LSB]};
                    CPL_BLUE: rd_mux = {2'h0, staging_reg[`CPL_BLUE_MSB:`CPL_BLUE_LSB]};
                    default: rd_mux = {2'h0, staging_reg[`CPL_RED_MSB:`CPL_RED_LSB]};
                endcase
            end
        endcase
    end

    // enable trails the strobe by one clock; turn-off is one period late
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_host_data_oe <= 1'b0;
            o_host_data <= 8'h00;
        end else begin
            o_host_data_oe <= !i_read_strobe_n;
            if (!i_read_strobe_n) begin
                o_host_data <= rd_mux;
            end
        end
    end

    // pixel stage 1: input latch, stalls only when the buffer is full
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1_valid_reg <= 1'b0;
            s1_idx_reg <= 8'h00;
            s1_on_reg <= 1'b0;
        end else if (pix_in.ready) begin
            s1_valid_reg <= 1'b1;
            s1_idx_reg <= i_pixel_index_in;
            s1_on_reg <= i_video_off_n;
        end
    end

    // a palette write steals the lookup port for that clock
    assign look_idx = pal_we ? ptr_reg : (s1_idx_reg & mask_reg);
    assign look_data = pal_mem[look_idx];
    assign pix_in.valid = s1_valid_reg;
    assign pix_in.data = s1_on_reg ? look_data : 18'h00000;

    cpl_pix_buf #(
        .W(18),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .s_in(pix_in.snk),
        .s_out(pix_out.src)
    );

    assign out_ready = !o_dac_valid || i_dac_ready;
    assign pix_out.ready = out_ready;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_dac_valid <= 1'b0;
            o_dac_red <= 6'h00;
            o_dac_green <= 6'h00;
            o_dac_blue <= 6'h00;
        end else if (out_ready) begin
            o_dac_valid <= pix_out.valid;
            if (pix_out.valid) begin
                o_dac_red <= pix_out.data[`CPL_RED_MSB:`CPL_RED_LSB];
                o_dac_green <= pix_out.data[`CPL_GREEN_MSB:`CPL_GREEN_LSB];
                o_dac_blue <= pix_out.data[`CPL_BLUE_MSB:`CPL_BLUE_LSB];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pixel_ready <= 1'b0;
        end else begin
            o_pixel_ready <= pix_in.ready;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_blank_zero: assert property (
        (!i_video_off_n && pix_in.ready && out_ready) ##1 i_dac_ready[*2]
        |-> ##1 (o_dac_valid && o_dac_red == 6'h00 && o_dac_green == 6'h00
                 && o_dac_blue == 6'h00))
        else $error("blanked pixel not zero");

    a_mask_apply: assert property (
        pix_in.ready ##1 !pal_we |-> look_idx == ($past(i_pixel_index_in) & mask_reg))
        else $error("lookup index not masked");

    a_write_commit: assert property (
        (wr_rise && sel_reg == `CPL_SEL_COLOR && phase_reg == CPL_BLUE)
        |=> (ptr_reg == 8'($past(ptr_reg) + 1'b1)) && phase_reg == CPL_RED
            && pal_mem[$past(ptr_reg)] == $past(pal_wdata))
        else $error("color write not committed");

    a_ptr_restart: assert property (
        (wr_rise && sel_reg == `CPL_SEL_PTR_WR) |=> phase_reg == CPL_RED
            && ptr_reg == $past(wr_data_reg) && !read_mode_reg)
        else $error("pointer write did not restart");

    a_read_fetch: assert property (
        (wr_rise && sel_reg == `CPL_SEL_PTR_RD) |=> staging_reg == $past(fetch_data)
            && ptr_reg == 8'($past(wr_data_reg) + 1'b1) && read_mode_reg)
        else $error("read index fetch wrong");

    a_read_zero_msbs: assert property (
        ($past(!i_read_strobe_n) && sel_reg == `CPL_SEL_COLOR && $past(sel_reg) == sel_reg)
        |-> o_host_data[7:6] == 2'h0)
        else $error("color read msbs not zero");

    a_bus_release: assert property (
        (i_read_strobe_n && i_write_strobe_n)[*2] |-> !o_host_data_oe)
        else $error("data lines driven while idle");

    a_low_six: assert property (
        (wr_rise && sel_reg == `CPL_SEL_COLOR && phase_reg == CPL_RED)
        |=> staging_reg[`CPL_RED_MSB:`CPL_RED_LSB] == $past(wr_data_reg[5:0])
            && phase_reg == CPL_GREEN)
        else $error("red component not stored");

    a_read_reload: assert property (
        (rd_rise && sel_reg == `CPL_SEL_COLOR && phase_reg == CPL_BLUE && read_mode_reg)
        |=> staging_reg == $past(fetch_data) && ptr_reg == 8'($past(ptr_reg) + 1'b1))
        else $error("read sequence did not reload");

    a_reset_phase: assert property (
        disable iff (1'b0) i_srst |=> phase_reg == CPL_RED && !o_host_data_oe && !o_dac_valid)
        else $error("reset did not clear sequence");

    c_write_seq: cover property (wr_rise && sel_reg == `CPL_SEL_COLOR && phase_reg == CPL_BLUE);
    c_read_seq: cover property (rd_rise && sel_reg == `CPL_SEL_COLOR && phase_reg == CPL_BLUE
        && read_mode_reg);
    c_blank_out: cover property (o_dac_valid && !s1_on_reg);
    c_stall: cover property (!pix_in.ready && s1_valid_reg);
endmodule
`default_nettype wire

//--- hw/cpl_pix_buf.sv
`timescale 1ns/1ps
`default_nettype none
module cpl_pix_buf #(
    parameter int W = 18,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // streams
    cpl_stream_if.snk s_in,
    cpl_stream_if.src s_out
);
    import cpl_pkg::*;
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [IW-1:0] wr_idx_reg;
    logic [IW-1:0] rd_idx_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign s_in.ready = (count_reg != FULL);
    assign s_out.valid = (count_reg != '0);
    assign s_out.data = mem_reg[rd_idx_reg];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_idx_reg] <= s_in.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
        end else begin
            if (push) begin
                wr_idx_reg <= (wr_idx_reg == LAST) ? '0 : IW'(wr_idx_reg + 1'b1);
            end
            if (pop) begin
                rd_idx_reg <= (rd_idx_reg == LAST) ? '0 : IW'(rd_idx_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_reg <= CW'(count_reg - 1'b1);
        end
    end
endmodule
`default_nettype wire

//--- hw/cpl_pkg.sv
package cpl_pkg;
    typedef logic [5:0] cpl_comp6_t;
    typedef logic [7:0] cpl_byte_t;
    typedef logic [1:0] cpl_sel_t;
    typedef enum logic [1:0] {CPL_RED, CPL_GREEN, CPL_BLUE} cpl_phase_t;
endpackage

//--- hw/cpl_regs.svh
`ifndef CPL_REGS_SVH
`define CPL_REGS_SVH

// register select codes, written as {reg_select_hi, reg_select_lo}
`define CPL_SEL_PTR_WR 2'h0
`define CPL_SEL_COLOR 2'h1
`define CPL_SEL_MASK 2'h2
`define CPL_SEL_PTR_RD 2'h3

// color staging field layout
`define CPL_RED_MSB 17
`define CPL_RED_LSB 12
`define CPL_GREEN_MSB 11
`define CPL_GREEN_LSB 6
`define CPL_BLUE_MSB 5
`define CPL_BLUE_LSB 0

// reset values
`define CPL_PTR_RST 8'h00
`define CPL_MASK_RST 8'hFF
`define CPL_STAGE_RST 18'h00000

// timing
`define CPL_CLK_PERIOD_NS 100
`define CPL_PIPE_CYCLES 3
`define CPL_RD_FETCH_CYCLES 6
`define CPL_DISTURB_CYCLES 2

`endif

//--- hw/cpl_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpl_stream_if #(parameter int W = 18);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

//--- sim/cpl_host_model.sv
`include "cpl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpl_host_model (
    // clock
    input wire logic i_clk,
    // device data lines
    input wire cpl_pkg::cpl_byte_t i_dev_data,
    input wire logic i_dev_oe,
    // host bus
    output logic o_reg_select_lo,
    output logic o_reg_select_hi,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output var cpl_pkg::cpl_byte_t o_bus
);
    import cpl_pkg::*;
    cpl_byte_t drv_val;
    cpl_byte_t last_reg;
    logic drv_en;

    initial begin
        {o_reg_select_hi, o_reg_select_lo} = 2'h0;
        o_read_strobe_n = 1'b1;
        o_write_strobe_n = 1'b1;
        drv_val = 8'h00;
        last_reg = 8'h00;
        drv_en = 1'b0;
    end

    // no pull on the lines: a released bus toggles so a stale byte never reads as good
    always_comb o_bus = i_dev_oe ? i_dev_data : (drv_en ? drv_val : ~last_reg);
    always @(posedge i_clk) last_reg <= o_bus;

    task automatic wr(input cpl_sel_t sel, input cpl_byte_t data);
        @(posedge i_clk);
        {o_reg_select_hi, o_reg_select_lo} <= sel;
        o_write_strobe_n <= 1'b0;
        drv_val <= data;
        drv_en <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_write_strobe_n <= 1'b1;
        @(posedge i_clk);
        drv_en <= 1'b0;
        repeat (3) @(posedge i_clk);
        if (sel == `CPL_SEL_PTR_RD) repeat (6) @(posedge i_clk);
    endtask

    task automatic rd(input cpl_sel_t sel, output cpl_byte_t data, output logic oe_on,
                      output logic oe_off);
        @(posedge i_clk);
        {o_reg_select_hi, o_reg_select_lo} <= sel;
        o_read_strobe_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        data = o_bus;
        oe_on = i_dev_oe;
        o_read_strobe_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        oe_off = i_dev_oe;
        repeat (2) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- sim/cpl_palette_port_tb.sv
`include "cpl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpl_palette_port_tb;
    import cpl_pkg::*;
    logic clk;
    logic srst;
    logic sel_lo;
    logic sel_hi;
    logic rd_n;
    logic wr_n;
    logic dev_oe;
    logic voff_n;
    logic pix_rdy;
    logic dac_vld;
    logic dac_rdy;
    cpl_byte_t bus;
    cpl_byte_t dev_data;
    cpl_byte_t pix;
    cpl_comp6_t dac_r;
    cpl_comp6_t dac_g;
    cpl_comp6_t dac_b;
    int n_errors;
    int comparisons;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    cpl_palette_port #(.ENTRIES(256), .BUF_DEPTH(2)) uut (
        .i_clk(clk), .i_srst(srst),
        .i_reg_select_lo(sel_lo), .i_reg_select_hi(sel_hi),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
        .i_host_data(bus), .o_host_data(dev_data), .o_host_data_oe(dev_oe),
        .i_pixel_index_in(pix), .i_video_off_n(voff_n), .o_pixel_ready(pix_rdy),
        .o_dac_red(dac_r), .o_dac_green(dac_g), .o_dac_blue(dac_b),
        .o_dac_valid(dac_vld), .i_dac_ready(dac_rdy)
    );

    cpl_host_model host (
        .i_clk(clk), .i_dev_data(dev_data), .i_dev_oe(dev_oe),
        .o_reg_select_lo(sel_lo), .o_reg_select_hi(sel_hi),
        .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_bus(bus)
    );

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic hrd(input cpl_sel_t sel, input cpl_byte_t exp);
        cpl_byte_t d;
        logic on;
        logic off;
        host.rd(sel, d, on, off);
        chk({10'h000, d}, {10'h000, exp}, "host read data");
        chk({17'h00000, on}, 18'h00001, "data lines driven in read");
        chk({17'h00000, off}, 18'h00000, "data lines released");
    endtask

    // top bits set on purpose, the device must drop them
    task automatic wr_color(input cpl_comp6_t r, input cpl_comp6_t g, input cpl_comp6_t b);
        host.wr(`CPL_SEL_COLOR, {2'h3, r});
        host.wr(`CPL_SEL_COLOR, {2'h3, g});
        host.wr(`CPL_SEL_COLOR, {2'h3, b});
    endtask

    task automatic rd_color(input cpl_comp6_t r, input cpl_comp6_t g, input cpl_comp6_t b);
        hrd(`CPL_SEL_COLOR, {2'h0, r});
        hrd(`CPL_SEL_COLOR, {2'h0, g});
        hrd(`CPL_SEL_COLOR, {2'h0, b});
    endtask

    task automatic pix_chk(input cpl_byte_t idx, input logic von, input logic [17:0] exp);
        @(posedge clk);
        pix <= idx;
        voff_n <= von;
        repeat (3) @(posedge clk);
        #1;
        chk({dac_r, dac_g, dac_b}, exp, "dac channels");
        chk({17'h00000, dac_vld}, 18'h00001, "dac valid");
    endtask

    task automatic t_reset();
        hrd(`CPL_SEL_PTR_WR, `CPL_PTR_RST);
        hrd(`CPL_SEL_PTR_RD, `CPL_PTR_RST);
        hrd(`CPL_SEL_MASK, `CPL_MASK_RST);
        wr_color(6'h11, 6'h12, 6'h13);
        hrd(`CPL_SEL_PTR_WR, 8'h01);
        $display("test reset done");
    endtask

    task automatic t_write_read();
        host.wr(`CPL_SEL_PTR_WR, 8'h0A);
        wr_color(6'h01, 6'h02, 6'h03);
        wr_color(6'h3F, 6'h00, 6'h15);
        // entry after the last one read back must hold a value for the reload
        wr_color(6'h2A, 6'h15, 6'h0C);
        hrd(`CPL_SEL_PTR_WR, 8'h0D);
        host.wr(`CPL_SEL_PTR_RD, 8'h0A);
        hrd(`CPL_SEL_PTR_RD, 8'h0B);
        rd_color(6'h01, 6'h02, 6'h03);
        rd_color(6'h3F, 6'h00, 6'h15);
        hrd(`CPL_SEL_PTR_RD, 8'h0D);
        $display("test write and read back done");
    endtask

    task automatic t_abort();
        host.wr(`CPL_SEL_PTR_WR, 8'h1A);
        host.wr(`CPL_SEL_COLOR, 8'h3F);
        host.wr(`CPL_SEL_COLOR, 8'h3F);
        host.wr(`CPL_SEL_PTR_WR, 8'h1A);
        wr_color(6'h05, 6'h06, 6'h07);
        hrd(`CPL_SEL_PTR_WR, 8'h1B);
        host.wr(`CPL_SEL_PTR_RD, 8'h1A);
        hrd(`CPL_SEL_COLOR, 8'h05);
        host.wr(`CPL_SEL_PTR_RD, 8'h0A);
        rd_color(6'h01, 6'h02, 6'h03);
        $display("test abandoned sequence done");
    endtask

    task automatic t_mask_blank();
        host.wr(`CPL_SEL_MASK, 8'h0F);
        hrd(`CPL_SEL_MASK, 8'h0F);
        host.wr(`CPL_SEL_PTR_RD, 8'h1A);
        hrd(`CPL_SEL_COLOR, 8'h05);
        pix_chk(8'hFA, 1'b1, {6'h01, 6'h02, 6'h03});
        pix_chk(8'h1A, 1'b1, {6'h01, 6'h02, 6'h03});
        host.wr(`CPL_SEL_MASK, 8'hFF);
        pix_chk(8'h1A, 1'b1, {6'h05, 6'h06, 6'h07});
        pix_chk(8'h1A, 1'b0, 18'h00000);
        pix_chk(8'h0B, 1'b1, {6'h3F, 6'h00, 6'h15});
        $display("test mask and blanking done");
    endtask

    // receiver stalls until the two-entry buffer refuses, then drains it
    task automatic t_stall();
        int i;
        pix_chk(8'h0A, 1'b1, {6'h01, 6'h02, 6'h03});
        @(posedge clk);
        dac_rdy <= 1'b0;
        pix <= 8'h0B;
        for (i = 0; i < 12 && pix_rdy !== 1'b0; i++) @(posedge clk);
        if (i == 12) begin
            n_errors++;
            $display("CHECK FAILED at %0t: buffer never refused", $time);
            stop_test();
        end
        #1;
        chk({dac_r, dac_g, dac_b}, {6'h01, 6'h02, 6'h03}, "held while stalled");
        @(posedge clk);
        dac_rdy <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk({dac_r, dac_g, dac_b}, {6'h3F, 6'h00, 6'h15}, "drained output");
        chk({17'h00000, pix_rdy}, 18'h00001, "input accepted again");
        $display("test receiver stall done");
    endtask

    initial begin
        n_errors = 0;
        comparisons = 0;
        srst = 1'b1;
        pix = 8'h00;
        voff_n = 1'b1;
        dac_rdy = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_write_read();
        t_abort();
        t_mask_blank();
        t_stall();
        stop_test();
    end
endmodule
`default_nettype wire
